// ===== reset_recovery_pkg.sv
// Constants for the reset, stop recovery and watchdog controller
package reset_recovery_pkg;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    localparam logic [3:0] BANK_F = 4'hF;
    localparam logic [3:0] STOP_RECOVERY_OFS = 4'hB;
    localparam logic [3:0] WATCHDOG_MODE_OFS = 4'hF;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SR_DIV_BIT = 0;
    localparam int SR_SRC_LSB = 2;
    localparam int SR_SRC_MSB = 4;
    localparam int SR_DELAY_BIT = 5;
    localparam int SR_LEVEL_BIT = 6;
    localparam int SR_FLAG_BIT = 7;
    localparam int WD_TAP_LSB = 0;
    localparam int WD_TAP_MSB = 1;
    localparam int WD_HALT_BIT = 2;
    localparam int WD_STOP_BIT = 3;
    localparam int WD_CLKSEL_BIT = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [6:0] STOP_RECOVERY_RESET = 7'h20;
    localparam logic [4:0] WATCHDOG_MODE_RESET = 5'h1B;

    // ----------------------------------------
    // Recovery sources
    // ----------------------------------------
    localparam logic [2:0] SRC_POR_ONLY = 3'h0;
    localparam logic [2:0] SRC_NAND_P2_LOW = 3'h1;
    localparam logic [2:0] SRC_NAND_P2_ALL = 3'h2;
    localparam logic [2:0] SRC_NOR_P3 = 3'h3;
    localparam logic [2:0] SRC_NAND_P3 = 3'h4;
    localparam logic [2:0] SRC_NOR_P3_P0 = 3'h5;
    localparam logic [2:0] SRC_NAND_P3_P0 = 3'h6;
    localparam logic [2:0] SRC_NAND_P3_P2 = 3'h7;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int POR_TIME_MS = 5;
    localparam int POR_CYCLES_DEFAULT = POR_TIME_MS * 1000 * CLOCK_MHZ;
    localparam logic [6:0] LOCK_CYCLES = 7'h3C;
    localparam logic [15:0] WD_TAP0_TICKS = 16'h0100;
    localparam logic [15:0] WD_TAP1_TICKS = 16'h0400;
    localparam logic [15:0] WD_TAP2_TICKS = 16'h1000;
    localparam logic [15:0] WD_TAP3_TICKS = 16'h4000;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_RUN = 2'b01,
        ST_STOP = 2'b10
    } seq_state_e;

endpackage : reset_recovery_pkg

// ===== reset_recovery_watchdog_ctrl.sv
// Power-up delay, stop recovery, watchdog and port configuration control
// Functional notes
// - Delay starts on power good, timeout, recovery
// - Delay lasts nominally five milliseconds
// - Execution held until delay completes
// - Bit 5 selects delay after stop
// - Config bit 0 routes comparators to port 3
// - Config bit 2 selects push-pull or open-drain
// - Only top recovery bit is readable
// - Recovery flag set by hardware, power clears
// - Bit 6 selects wake level
// - Bits 4:2 select recovery source
// - Bit 0 selects divide by sixteen
// - Recovery register at bank F 0B
// - Watchdog terminal count forces reset
// - First instruction starts, later ones refresh
// - Watchdog instruction updates condition flags
// - Mode bit 4 selects watchdog clock
// - Mode bits 1:0 select timeout tap
// - Mode bits 2,3 keep counting halt/stop
// - Mode bits 7:5 reserved
// - Mode writes only in first 60 cycles
// - Mode register write-only at bank F 0F
// - Pointer low nibble selects bank
`timescale 1ns/100ps
`default_nettype none

module reset_recovery_watchdog_ctrl
    import reset_recovery_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYCLES_DEFAULT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_good,
    input wire logic [3:0] register_pointer,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic watchdog_instr,
    input wire logic stop_request,
    input wire logic halt_mode,
    input wire logic rc_osc_tick,
    input wire logic crystal_input_tick,
    input wire logic [7:0] port2_in,
    input wire logic [3:1] port3_in,
    input wire logic [7:0] port0_in,
    input wire logic comparator_route_en,
    input wire logic port0_push_pull_en,
    input wire logic [1:0] comparator_out,
    input wire logic port3_line_four_data,
    input wire logic port3_line_seven_data,
    input wire logic [7:0] port0_data,
    output logic [7:0] reg_rdata,
    output logic hold_execution,
    output logic watchdog_reset,
    output logic flags_update,
    output logic clock_div16,
    output logic recovery_flag,
    output logic port3_line_four,
    output logic port3_line_seven,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe_n
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_e state_reg, state_next;
    logic [19:0] por_cnt_reg, por_cnt_next;
    logic hold_reg, hold_next;
    logic power_ok_reg;
    logic [6:0] lock_cnt_reg, lock_cnt_next;
    logic wd_enabled_reg, wd_enabled_next;
    logic [15:0] wd_cnt_reg, wd_cnt_next;
    logic wd_reset_reg, wd_reset_next;
    logic flags_update_reg, flags_update_next;
    logic [6:0] recovery_ctl_reg, recovery_ctl_next;
    logic flag_reg, flag_next;
    logic [4:0] wd_mode_reg, wd_mode_next;
    logic [7:0] rdata_reg, rdata_next;
    logic line_four_reg, line_seven_reg;
    logic [7:0] p0_out_reg, p0_oe_n_reg;

    // ----------------------------------------
    // Decode and events
    // ----------------------------------------
    logic bank_f, wr_recovery, wr_wd_mode, rd_recovery, rd_wd_mode;
    logic power_rise, src_val, wake, por_start, wd_tick, wd_active;
    logic wd_expire, wd_kick, lock_open;
    logic [15:0] tap_ticks;

    assign bank_f = (register_pointer == BANK_F);
    assign wr_recovery = reg_wr && bank_f && (reg_addr == STOP_RECOVERY_OFS);
    assign wr_wd_mode = reg_wr && bank_f && (reg_addr == WATCHDOG_MODE_OFS);
    assign rd_recovery = reg_rd && bank_f && (reg_addr == STOP_RECOVERY_OFS);
    assign rd_wd_mode = reg_rd && bank_f && (reg_addr == WATCHDOG_MODE_OFS);
    assign power_rise = power_good && !power_ok_reg;

    // Recovery source evaluation
    always_comb begin
        case (recovery_ctl_reg[SR_SRC_MSB:SR_SRC_LSB])
            SRC_POR_ONLY: src_val = 1'b0;
            SRC_NAND_P2_LOW: src_val = ~&port2_in[3:0];
            SRC_NAND_P2_ALL: src_val = ~&port2_in;
            SRC_NOR_P3: src_val = ~|port3_in;
            SRC_NAND_P3: src_val = ~&port3_in;
            SRC_NOR_P3_P0: src_val = ~|{port3_in, port0_in[0], port0_in[7]};
            SRC_NAND_P3_P0: src_val = ~&{port3_in, port0_in[0], port0_in[7]};
            SRC_NAND_P3_P2: src_val = ~&{port3_in, port2_in[2:0]};
            default: src_val = 1'b0;
        endcase
    end

    assign wake = (state_reg == ST_STOP) &&
        (recovery_ctl_reg[SR_SRC_MSB:SR_SRC_LSB] != SRC_POR_ONLY) &&
        (src_val == recovery_ctl_reg[SR_LEVEL_BIT]);

    // Watchdog clock, tap and run conditions
    assign wd_tick = wd_mode_reg[WD_CLKSEL_BIT] ? crystal_input_tick : rc_osc_tick;
    always_comb begin
        case (wd_mode_reg[WD_TAP_MSB:WD_TAP_LSB])
            2'h0: tap_ticks = WD_TAP0_TICKS;
            2'h1: tap_ticks = WD_TAP1_TICKS;
            2'h2: tap_ticks = WD_TAP2_TICKS;
            2'h3: tap_ticks = WD_TAP3_TICKS;
            default: tap_ticks = WD_TAP3_TICKS;
        endcase
    end
    assign wd_active = wd_enabled_reg &&
        !((state_reg == ST_STOP) && !wd_mode_reg[WD_STOP_BIT]) &&
        !((state_reg == ST_RUN) && halt_mode && !wd_mode_reg[WD_HALT_BIT]);
    assign wd_kick = watchdog_instr && (state_reg == ST_RUN);
    assign wd_expire = wd_active && wd_tick && !wd_kick &&
        (wd_cnt_reg == 16'h0000);
    assign lock_open = (state_reg == ST_RUN) && (lock_cnt_reg < LOCK_CYCLES);
    assign por_start = power_rise || wd_expire ||
        (wake && recovery_ctl_reg[SR_DELAY_BIT]);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        por_cnt_next = por_cnt_reg;
        lock_cnt_next = lock_cnt_reg;
        flag_next = flag_reg;
        if (power_rise) begin
            flag_next = 1'b0;
        end
        if (wake) begin
            flag_next = 1'b1;
        end
        if (!power_good) begin
            state_next = ST_HOLD;
            por_cnt_next = 20'h00000;
        end else if (por_start) begin
            state_next = ST_HOLD;
            por_cnt_next = 20'h00000;
        end else begin
            case (state_reg)
                ST_HOLD: begin
                    if (por_cnt_reg == 20'(POR_CYCLES - 1)) begin
                        state_next = ST_RUN;
                        lock_cnt_next = 7'h00;
                    end else begin
                        por_cnt_next = por_cnt_reg + 20'h00001;
                    end
                end
                ST_RUN: begin
                    if (lock_cnt_reg < LOCK_CYCLES) begin
                        lock_cnt_next = lock_cnt_reg + 7'h01;
                    end
                    if (stop_request) begin
                        state_next = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (wake) begin
                        state_next = ST_RUN;
                        lock_cnt_next = 7'h00;
                    end
                end
                default: state_next = ST_HOLD;
            endcase
        end
        hold_next = (state_next == ST_HOLD);
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    always_comb begin
        wd_enabled_next = wd_enabled_reg;
        wd_cnt_next = wd_cnt_reg;
        wd_reset_next = wd_expire;
        flags_update_next = wd_kick;
        if (state_reg == ST_HOLD || !power_good) begin
            wd_enabled_next = 1'b0;
        end else if (wd_kick) begin
            wd_enabled_next = 1'b1;
            wd_cnt_next = tap_ticks;
        end else if (wd_expire) begin
            wd_enabled_next = 1'b0;
        end else if (wd_active && wd_tick) begin
            wd_cnt_next = wd_cnt_reg - 16'h0001;
        end
    end

    // ----------------------------------------
    // Registers and read path
    // ----------------------------------------
    always_comb begin
        recovery_ctl_next = recovery_ctl_reg;
        wd_mode_next = wd_mode_reg;
        rdata_next = 8'h00;
        if (wr_recovery) begin
            recovery_ctl_next = reg_wdata[6:0];
        end
        if (wr_wd_mode && lock_open) begin
            wd_mode_next = reg_wdata[4:0];
        end
        if (rd_recovery) begin
            rdata_next = {flag_reg, 7'h00};
        end else if (rd_wd_mode) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_HOLD;
            por_cnt_reg <= 20'h00000;
            hold_reg <= 1'b1;
            power_ok_reg <= 1'b0;
            lock_cnt_reg <= 7'h00;
            wd_enabled_reg <= 1'b0;
            wd_cnt_reg <= 16'h0000;
            wd_reset_reg <= 1'b0;
            flags_update_reg <= 1'b0;
            recovery_ctl_reg <= STOP_RECOVERY_RESET;
            flag_reg <= 1'b0;
            wd_mode_reg <= WATCHDOG_MODE_RESET;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            por_cnt_reg <= por_cnt_next;
            hold_reg <= hold_next;
            power_ok_reg <= power_good;
            lock_cnt_reg <= lock_cnt_next;
            wd_enabled_reg <= wd_enabled_next;
            wd_cnt_reg <= wd_cnt_next;
            wd_reset_reg <= wd_reset_next;
            flags_update_reg <= flags_update_next;
            recovery_ctl_reg <= recovery_ctl_next;
            flag_reg <= flag_next;
            wd_mode_reg <= wd_mode_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Port configuration
    // ----------------------------------------
    logic line_four_next, line_seven_next;
    logic [7:0] p0_oe_n_next;

    always_comb begin
        line_four_next = comparator_route_en ? comparator_out[0] : port3_line_four_data;
        line_seven_next = comparator_route_en ? comparator_out[1] : port3_line_seven_data;
        p0_oe_n_next = port0_push_pull_en ? 8'h00 : port0_data;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            line_four_reg <= 1'b0;
            line_seven_reg <= 1'b0;
            p0_out_reg <= 8'h00;
            p0_oe_n_reg <= 8'hFF;
        end else begin
            line_four_reg <= line_four_next;
            line_seven_reg <= line_seven_next;
            p0_out_reg <= port0_data;
            p0_oe_n_reg <= p0_oe_n_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign hold_execution = hold_reg;
    assign watchdog_reset = wd_reset_reg;
    assign flags_update = flags_update_reg;
    assign clock_div16 = recovery_ctl_reg[SR_DIV_BIT];
    assign recovery_flag = flag_reg;
    assign port3_line_four = line_four_reg;
    assign port3_line_seven = line_seven_reg;
    assign port0_out = p0_out_reg;
    assign port0_oe_n = p0_oe_n_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence delay_started_s;
        power_good && por_start;
    endsequence

    sequence held_s;
        hold_execution [*8];
    endsequence

    delay_hold_start_a: assert property (delay_started_s |=> held_s)
        else $error("Delay start did not hold execution");
    delay_length_a: assert property ($fell(hold_execution) |->
        $past(por_cnt_reg) == 20'(POR_CYCLES - 1))
        else $error("Delay ended at wrong count");
    exec_hold_a: assert property (hold_execution && por_cnt_reg != 20'(POR_CYCLES - 1) |=>
        hold_execution)
        else $error("Execution not held during delay");
    stop_bypass_a: assert property (power_good && wake && !recovery_ctl_reg[SR_DELAY_BIT] &&
        !wd_expire |=> !hold_execution && state_reg == ST_RUN)
        else $error("Delay bypass after stop failed");
    flag_set_a: assert property (wake |=> recovery_flag)
        else $error("Recovery flag not set");
    flag_sticky_a: assert property (recovery_flag && !power_rise |=> recovery_flag)
        else $error("Recovery flag cleared without power cycle");
    mode_lock_a: assert property (lock_cnt_reg == LOCK_CYCLES |=> $stable(wd_mode_reg))
        else $error("Watchdog mode changed after lock");
    wd_timeout_a: assert property (power_good && wd_expire |=>
        watchdog_reset && hold_execution ##1 !watchdog_reset)
        else $error("Watchdog timeout did not reset");
    wd_refresh_a: assert property (wd_kick && power_good |=>
        wd_enabled_reg && wd_cnt_reg == $past(tap_ticks))
        else $error("Watchdog refresh failed");
    flag_update_a: assert property (wd_kick |=> flags_update)
        else $error("Condition flags not updated");
    mode_read_a: assert property (rd_wd_mode |=> reg_rdata == 8'h00)
        else $error("Watchdog mode register readable");
    recovery_read_a: assert property (rd_recovery |=> reg_rdata[6:0] == 7'h00)
        else $error("Write-only recovery bits readable");

endmodule : reset_recovery_watchdog_ctrl

`default_nettype wire

// ===== cpu_core_model.sv
// Behavioural processor core issuing register accesses and watchdog instructions
`timescale 1ns/100ps
`default_nettype none

module cpu_core_model (
    input wire logic clock,
    input wire logic hold_execution,
    input wire logic [7:0] reg_rdata,
    input wire logic flags_update,
    output logic [3:0] register_pointer,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic watchdog_instr,
    output logic stop_request
);
    // ----------------------------------------
    // Instruction tasks
    // ----------------------------------------
    initial begin
        register_pointer = 4'h0;
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        watchdog_instr = 1'b0;
        stop_request = 1'b0;
    end

    // Nothing is executed while execution is held
    task automatic start;
        while (hold_execution !== 1'b0) @(negedge clock);
        @(posedge clock);
    endtask : start

    task automatic wr(input logic [3:0] ptr, input logic [3:0] a, input logic [7:0] d);
        start();
        register_pointer <= ptr;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // Released data bus does not keep the last value
        reg_wdata <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] ptr, input logic [3:0] a, output logic [7:0] d);
        start();
        register_pointer <= ptr;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Watchdog start or refresh, flag update seen the cycle after
    task automatic instr(output logic fl);
        start();
        watchdog_instr <= 1'b1;
        @(posedge clock);
        watchdog_instr <= 1'b0;
        #1;
        fl = flags_update;
    endtask : instr

    task automatic stop_core;
        start();
        stop_request <= 1'b1;
        @(posedge clock);
        stop_request <= 1'b0;
        #1;
    endtask : stop_core
endmodule : cpu_core_model
`default_nettype wire

// ===== reset_recovery_watchdog_ctrl_tb.sv
// Self-checking bench for the reset, recovery and watchdog controller
`timescale 1ns/100ps
`default_nettype none

module reset_recovery_watchdog_ctrl_tb
    import reset_recovery_pkg::*;
;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam int POR = 20;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic power_good = 1'b1;
    logic halt_mode = 1'b0;
    logic rc_osc_tick = 1'b1;
    logic crystal_input_tick = 1'b0;
    logic comparator_route_en = 1'b0;
    logic port0_push_pull_en = 1'b0;
    logic port3_line_four_data = 1'b0;
    logic port3_line_seven_data = 1'b0;
    logic [1:0] comparator_out = 2'h0;
    logic [7:0] port2_in = 8'hFF;
    logic [3:1] port3_in = 3'h7;
    logic [7:0] port0_data = 8'h00;
    logic [7:0] port0_in;
    logic [3:0] register_pointer, reg_addr;
    logic reg_wr, reg_rd, watchdog_instr, stop_request;
    logic [7:0] reg_wdata, reg_rdata, port0_out, port0_oe_n;
    logic hold_execution, watchdog_reset, flags_update, clock_div16;
    logic recovery_flag, port3_line_four, port3_line_seven;
    int num_errors = 0;
    int tests_run = 0;

    // Port 0 pins with pull-ups where not driven
    assign port0_in = port0_out | port0_oe_n;

    initial begin
        forever #2.5 clock = ~clock;
    end

    reset_recovery_watchdog_ctrl #(.POR_CYCLES(POR)) dut (
        .clock, .rst_n, .power_good, .register_pointer, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .watchdog_instr, .stop_request, .halt_mode,
        .rc_osc_tick, .crystal_input_tick, .port2_in, .port3_in, .port0_in,
        .comparator_route_en, .port0_push_pull_en, .comparator_out,
        .port3_line_four_data, .port3_line_seven_data, .port0_data, .reg_rdata,
        .hold_execution, .watchdog_reset, .flags_update, .clock_div16,
        .recovery_flag, .port3_line_four, .port3_line_seven, .port0_out,
        .port0_oe_n
    );

    cpu_core_model core (
        .clock, .hold_execution, .reg_rdata, .flags_update, .register_pointer,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .watchdog_instr, .stop_request
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    // Cycle of the first watchdog reset pulse, or -1
    task automatic watch(input int limit, output int at);
        at = -1;
        for (int i = 0; i < limit && at < 0; i++) begin
            @(posedge clock);
            #1;
            if (watchdog_reset === 1'b1) at = i;
        end
    endtask : watch

    task automatic print_verdict;
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic fl;
        int n;
        int at;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        n = 0;
        while (hold_execution !== 1'b0 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(16'(n >= POR && n <= POR + 4), 16'h1);
        core.wr(BANK_F, WATCHDOG_MODE_OFS, 8'h00);
        core.instr(fl);
        check(16'(fl), 16'h1);
        core.rd(BANK_F, WATCHDOG_MODE_OFS, d);
        check(16'(d), 16'h0);
        watch(180, at);
        check(16'(at), 16'hFFFF);
        core.instr(fl);
        @(posedge clock) halt_mode <= 1'b1;
        watch(300, at);
        check(16'(at), 16'hFFFF);
        @(posedge clock) halt_mode <= 1'b0;
        watch(50, at);
        check(16'(at), 16'hFFFF);
        watch(260, at);
        check(16'(at >= 190 && at <= 215), 16'h1);
        check(16'(hold_execution), 16'h1);
        core.wr(BANK_F, WATCHDOG_MODE_OFS, 8'h10);
        core.instr(fl);
        watch(300, at);
        check(16'(at), 16'hFFFF);
        core.wr(BANK_F, WATCHDOG_MODE_OFS, 8'h00);
        core.instr(fl);
        watch(300, at);
        check(16'(at), 16'hFFFF);
        @(posedge clock) crystal_input_tick <= 1'b1;
        watch(300, at);
        check(16'(at >= 240 && at <= 262), 16'h1);
        @(posedge clock);
        crystal_input_tick <= 1'b0;
        comparator_route_en <= 1'b1;
        comparator_out <= 2'b01;
        port3_line_seven_data <= 1'b1;
        port0_data <= 8'h5A;
        cyc(2);
        check(16'({port3_line_four, port3_line_seven}), 16'h2);
        check(16'(port0_oe_n), 16'h5A);
        @(posedge clock);
        comparator_route_en <= 1'b0;
        port0_push_pull_en <= 1'b1;
        cyc(2);
        check(16'({port3_line_four, port3_line_seven}), 16'h1);
        check(16'({port0_oe_n, port0_out}), 16'h005A);
        core.wr(BANK_F, STOP_RECOVERY_OFS, 8'h45);
        cyc(1);
        check(16'(clock_div16), 16'h1);
        core.stop_core();
        cyc(10);
        check(16'(recovery_flag), 16'h0);
        @(posedge clock) port2_in <= 8'hF0;
        cyc(3);
        check(16'({recovery_flag, hold_execution}), 16'h2);
        core.rd(BANK_F, STOP_RECOVERY_OFS, d);
        check(16'(d), 16'h80);
        core.rd(4'h0, STOP_RECOVERY_OFS, d);
        check(16'(d), 16'h0);
        @(posedge clock) port2_in <= 8'hFF;
        core.wr(BANK_F, STOP_RECOVERY_OFS, 8'h64);
        core.stop_core();
        cyc(5);
        @(posedge clock) port2_in <= 8'hF0;
        cyc(3);
        check(16'({hold_execution, clock_div16}), 16'h2);
        cyc(POR + 5);
        @(posedge clock) power_good <= 1'b0;
        cyc(3);
        @(posedge clock) power_good <= 1'b1;
        cyc(3);
        check(16'({recovery_flag, hold_execution}), 16'h1);
        print_verdict();
    end
endmodule : reset_recovery_watchdog_ctrl_tb
`default_nettype wire
